// ==== core/sample_clock_pkg.sv ====
// Function
// [R1] divide the input clock by 1, 2 or 4 per the divide ratio register
// [R2] divided clock to the converter core has 50% duty cycle
// [R3] valid timing pulse forces divider counter to a programmed state
// [R4] host should set divide ratio before applying the input clock
// [R5] clock source must stay at or below 6 GHz divider limit
// [R6] divider phase steps by half an input period when enabled
// [R7] half-period register writes leave the serial link undisturbed
// [R8] 3-bit delay mode picks fine delay alone or fine plus superfine
// [R9] fine delay offers a 16-step and a 192-step option
// [R10] 8-bit fine delay register spans 192 delay steps
// [R11] 8-bit unsigned superfine register spans 128 steps of 0.25 ps
// [R12] superfine used only for delay mode 0x2 or 0x6
// [R13] delay settings apply at once after a register write
// [R14] enabling fine delay in the mode field resets the datapath
// [R15] fine and superfine amount writes neither disturb link nor reset datapath
// [R16] host should match digital and analog delay values
// [R17] two-stage duty stabilizer on from reset, set by two registers
// [R18] ratio codes are distinct for 1, 2, 4; unused codes divide by 1
// [R19] realignment on next input edge after pulse; stray divided edge suppressed
package sample_clock_pkg;
  localparam logic [15:0] addr_divide_ratio   = 16'h0108;
  localparam logic [15:0] addr_half_period    = 16'h0109;
  localparam logic [15:0] addr_delay_mode     = 16'h0110;
  localparam logic [15:0] addr_superfine      = 16'h0111;
  localparam logic [15:0] addr_fine           = 16'h0112;
  localparam logic [15:0] addr_stabilizer_one = 16'h011c;
  localparam logic [15:0] addr_stabilizer_two = 16'h011e;
  localparam logic [15:0] addr_status         = 16'h0120;

  // divide ratio register fields
  localparam int         ratio_lsb      = 0;
  localparam int         load_state_lsb = 4;
  localparam logic [1:0] ratio_div1     = 2'h0;
  localparam logic [1:0] ratio_div2     = 2'h1;
  localparam logic [1:0] ratio_div4     = 2'h2;

  localparam int half_enable_bit = 0;
  localparam int stab_enable_bit = 0;
  localparam int mode_lsb        = 0;

  localparam logic [2:0] mode_off         = 3'h0;
  localparam logic [2:0] mode_superfine_a = 3'h2;
  localparam logic [2:0] mode_superfine_b = 3'h6;
  localparam int         mode_short_bit   = 2;

  localparam logic [7:0] fine_steps_long  = 8'hc0;
  localparam logic [7:0] fine_steps_short = 8'h10;
  localparam logic [7:0] superfine_steps  = 8'h80;
  localparam int         superfine_step_fs = 250;

  localparam logic [7:0] reset_divide_ratio = 8'h00;
  localparam logic [7:0] reset_half_period  = 8'h00;
  localparam logic [7:0] reset_delay_mode   = 8'h00;
  localparam logic [7:0] reset_superfine    = 8'h00;
  localparam logic [7:0] reset_fine         = 8'h00;
  localparam logic [7:0] reset_stabilizer   = 8'h01;

  localparam int stab_period_width = 8;
endpackage

// ==== core/duty_cycle_stabilizer.sv ====
`timescale 1ns/1ps
`default_nettype none
module duty_cycle_stabilizer
  import sample_clock_pkg::*;
#(
  parameter int WIDTH = stab_period_width
)(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic in_level,
  input  wire logic in_rise,
  input  wire logic stage_one_enable,
  input  wire logic stage_two_enable,
  output logic      clk_out
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] period;
    logic             level;
  } stab_state_type;

  stab_state_type cur;
  stab_state_type next_state;
  logic           enabled;

  assign enabled = stage_one_enable | stage_two_enable;
  assign clk_out = cur.level;

  // measure the input period, then stay high for half of it
  always_comb
  begin
    next_state = cur;
    if (!enabled)
    begin
      next_state.level = in_level;
      next_state.count = '0;
    end
    else if (in_rise)
    begin
      next_state.period = (&cur.count) ? cur.count : cur.count + 1'b1;
      next_state.count  = '0;
      next_state.level  = 1'b1; // R2
    end
    else
    begin
      if (!(&cur.count))
        next_state.count = cur.count + 1'b1;
      if (next_state.count >= (cur.period >> 1))
        next_state.level = 1'b0; // R2
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      cur <= '0;
    else
      cur <= next_state;
  end

  a_stab_rise_high: assert property (@(posedge core_clk) disable iff (rst) // R2
    enabled && in_rise |=> clk_out)
    else $error("stabilizer output not high after input rise");

  a_stab_half_low: assert property (@(posedge core_clk) disable iff (rst) // R2
    enabled && !in_rise && (cur.count + 1'b1) >= (cur.period >> 1) && !(&cur.count)
    |=> !clk_out)
    else $error("stabilizer output not low after half period");
endmodule
`default_nettype wire

// ==== core/sample_clock_divider_delay.sv ====
`timescale 1ns/1ps
`default_nettype none
module sample_clock_divider_delay
  import sample_clock_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clk_in_pin,
  input  wire logic        sysref_pin,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wr_data,
  output logic      [7:0]  reg_rd_data,
  output logic             reg_rd_valid,
  output logic             div_clk,
  output logic             sample_strobe,
  output logic      [7:0]  fine_delay_applied,
  output logic      [7:0]  superfine_delay_applied,
  output logic             superfine_active,
  output logic             datapath_reset
);
  typedef struct packed {
    logic       clk_meta;
    logic       clk_sync;
    logic       clk_prev;
    logic       ref_meta;
    logic       ref_sync;
    logic       ref_prev;
    logic       sysref_pending;
    logic [1:0] cnt;
    logic       div_clk;
    logic       sample_strobe;
    logic       realigned;
    logic [7:0] divide_ratio;
    logic [7:0] half_period;
    logic [7:0] delay_mode;
    logic [7:0] superfine;
    logic [7:0] fine;
    logic [7:0] stab_one;
    logic [7:0] stab_two;
    logic [7:0] fine_out;
    logic [7:0] superfine_out;
    logic       superfine_on;
    logic       datapath_reset;
    logic [7:0] rd_data;
    logic       rd_valid;
  } core_state_type;

  core_state_type cur;
  core_state_type next_state;

  logic       in_rise;
  logic       in_fall;
  logic       div_edge;
  logic       ref_rise;
  logic       stab_level;
  logic [1:0] ratio;
  logic [1:0] load_state;
  logic [2:0] new_mode;
  logic [2:0] old_mode;
  logic       half_on;
  logic       wr_mode;

  function automatic logic [7:0] clamp_steps(input logic [7:0] value, input logic [7:0] steps);
    clamp_steps = (value >= steps) ? steps - 8'h01 : value;
  endfunction

  function automatic logic fine_enabled(input logic [2:0] mode);
    fine_enabled = (mode != mode_off);
  endfunction

  function automatic logic superfine_mode(input logic [2:0] mode);
    superfine_mode = (mode == mode_superfine_a) || (mode == mode_superfine_b);
  endfunction

  duty_cycle_stabilizer #(
    .WIDTH (stab_period_width)
  ) stabilizer (
    .core_clk         (core_clk),
    .rst              (rst),
    .in_level         (cur.clk_sync),
    .in_rise          (div_edge),
    .stage_one_enable (cur.stab_one[stab_enable_bit]), // R17
    .stage_two_enable (cur.stab_two[stab_enable_bit]), // R17
    .clk_out          (stab_level)
  );

  assign in_rise    = cur.clk_sync & ~cur.clk_prev;
  assign in_fall    = ~cur.clk_sync & cur.clk_prev;
  assign ref_rise   = cur.ref_sync & ~cur.ref_prev;
  assign half_on    = cur.half_period[half_enable_bit];
  assign div_edge   = half_on ? in_fall : in_rise; // R6
  assign ratio      = cur.divide_ratio[ratio_lsb +: 2];
  assign load_state = cur.divide_ratio[load_state_lsb +: 2];
  assign old_mode   = cur.delay_mode[mode_lsb +: 3];
  assign wr_mode    = reg_wr_en && (reg_addr == addr_delay_mode);

  always_comb
  begin
    next_state = cur;
    new_mode   = old_mode;

    // two-stage synchronisers for the clock and timing pins
    next_state.clk_meta = clk_in_pin;
    next_state.clk_sync = cur.clk_meta;
    next_state.clk_prev = cur.clk_sync;
    next_state.ref_meta = sysref_pin;
    next_state.ref_sync = cur.ref_meta;
    next_state.ref_prev = cur.ref_sync;

    // divider counter and timing-pulse realignment
    if (div_edge && cur.sysref_pending)
    begin
      next_state.cnt            = load_state; // R3
      next_state.sysref_pending = ref_rise;   // R19
    end
    else
    begin
      if (div_edge)
        next_state.cnt = cur.cnt + 2'h1;
      if (ref_rise)
        next_state.sysref_pending = 1'b1;
    end

    if (div_edge && cur.sysref_pending)
      next_state.div_clk = cur.div_clk; // R19
    else if (ratio == ratio_div4)
      next_state.div_clk = next_state.cnt[1]; // R1 R2
    else if (ratio == ratio_div2)
      next_state.div_clk = next_state.cnt[0]; // R1 R2
    else
      next_state.div_clk = stab_level; // R18 R2

    // catch-up level change after a counter load is no sample edge
    next_state.realigned     = div_edge && cur.sysref_pending
                               && (ratio == ratio_div2 || ratio == ratio_div4); // R19
    next_state.sample_strobe = next_state.div_clk & ~cur.div_clk & ~cur.realigned; // R19

    // register writes
    if (reg_wr_en)
    begin
      if (reg_addr == addr_divide_ratio)
        next_state.divide_ratio = reg_wr_data; // R1
      else if (reg_addr == addr_half_period)
        next_state.half_period = reg_wr_data; // R6 R7
      else if (reg_addr == addr_delay_mode)
        next_state.delay_mode = reg_wr_data; // R8
      else if (reg_addr == addr_superfine)
        next_state.superfine = reg_wr_data; // R11 R15
      else if (reg_addr == addr_fine)
        next_state.fine = reg_wr_data; // R10 R15
      else if (reg_addr == addr_stabilizer_one)
        next_state.stab_one = reg_wr_data; // R17
      else if (reg_addr == addr_stabilizer_two)
        next_state.stab_two = reg_wr_data; // R17
    end
    new_mode = next_state.delay_mode[mode_lsb +: 3];

    // delay settings follow the registers with no extra trigger
    if (!fine_enabled(new_mode))
      next_state.fine_out = 8'h00;
    else if (new_mode[mode_short_bit])
      next_state.fine_out = clamp_steps(next_state.fine, fine_steps_short); // R9 R13
    else
      next_state.fine_out = clamp_steps(next_state.fine, fine_steps_long); // R9 R10 R13

    next_state.superfine_on = superfine_mode(new_mode); // R12
    if (superfine_mode(new_mode))
      next_state.superfine_out = clamp_steps(next_state.superfine, superfine_steps); // R11 R13
    else
      next_state.superfine_out = 8'h00; // R12

    // only a mode write that turns fine delay on resets the datapath
    next_state.datapath_reset = wr_mode && fine_enabled(new_mode) && !fine_enabled(old_mode); // R14 R15 R7

    // register reads
    next_state.rd_valid = reg_rd_en;
    if (reg_rd_en)
    begin
      if (reg_addr == addr_divide_ratio)
        next_state.rd_data = cur.divide_ratio;
      else if (reg_addr == addr_half_period)
        next_state.rd_data = cur.half_period;
      else if (reg_addr == addr_delay_mode)
        next_state.rd_data = cur.delay_mode;
      else if (reg_addr == addr_superfine)
        next_state.rd_data = cur.superfine;
      else if (reg_addr == addr_fine)
        next_state.rd_data = cur.fine;
      else if (reg_addr == addr_stabilizer_one)
        next_state.rd_data = cur.stab_one;
      else if (reg_addr == addr_stabilizer_two)
        next_state.rd_data = cur.stab_two;
      else if (reg_addr == addr_status)
        next_state.rd_data = {4'h0, cur.sysref_pending, cur.div_clk, cur.cnt};
      else
        next_state.rd_data = 8'h00;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cur              <= '0;
      cur.divide_ratio <= reset_divide_ratio;
      cur.half_period  <= reset_half_period;
      cur.delay_mode   <= reset_delay_mode;
      cur.superfine    <= reset_superfine;
      cur.fine         <= reset_fine;
      cur.stab_one     <= reset_stabilizer; // R17
      cur.stab_two     <= reset_stabilizer; // R17
    end
    else
      cur <= next_state;
  end

  assign reg_rd_data             = cur.rd_data;
  assign reg_rd_valid            = cur.rd_valid;
  assign div_clk                 = cur.div_clk;
  assign sample_strobe           = cur.sample_strobe;
  assign fine_delay_applied      = cur.fine_out;
  assign superfine_delay_applied = cur.superfine_out;
  assign superfine_active        = cur.superfine_on;
  assign datapath_reset          = cur.datapath_reset;

  // checks
  a_div_two_toggle: assert property (@(posedge core_clk) disable iff (rst) // R1
    div_edge && !cur.sysref_pending && ratio == ratio_div2 && $stable(ratio)
    |=> div_clk != $past(div_clk))
    else $error("divide by two did not toggle on input edge");

  a_div_four_hold: assert property (@(posedge core_clk) disable iff (rst) // R1
    div_edge && !cur.sysref_pending && ratio == ratio_div4 && !cur.cnt[0] && $stable(ratio)
    |=> div_clk == $past(div_clk) ##1 !div_edge [*1])
    else $error("divide by four changed level too early");

  a_unused_ratio: assert property (@(posedge core_clk) disable iff (rst) // R18
    ratio == 2'h3 && !(div_edge && cur.sysref_pending) |=> div_clk == $past(stab_level))
    else $error("unused ratio code did not divide by one");

  a_sysref_realign: assert property (@(posedge core_clk) disable iff (rst) // R3
    div_edge && cur.sysref_pending |=> cur.cnt == $past(load_state))
    else $error("divider not loaded on timing pulse");

  a_stray_edge_hold: assert property (@(posedge core_clk) disable iff (rst) // R19
    div_edge && cur.sysref_pending |=> !sample_strobe && div_clk == $past(div_clk))
    else $error("divided edge not suppressed at realignment");

  a_half_edge_select: assert property (@(posedge core_clk) disable iff (rst) // R6
    half_on && in_rise |-> !div_edge)
    else $error("half period shift counted the wrong edge");

  a_no_reset_amount: assert property (@(posedge core_clk) disable iff (rst) // R15
    reg_wr_en && (reg_addr == addr_fine || reg_addr == addr_superfine || reg_addr == addr_half_period)
    |=> !datapath_reset)
    else $error("amount or half period write reset the datapath");

  a_fine_enable_reset: assert property (@(posedge core_clk) disable iff (rst) // R14
    wr_mode && old_mode == mode_off && reg_wr_data[2:0] != mode_off |=> datapath_reset ##1 !datapath_reset)
    else $error("fine delay enable did not pulse datapath reset");

  a_superfine_gate: assert property (@(posedge core_clk) disable iff (rst) // R12
    !superfine_active |-> superfine_delay_applied == 8'h00)
    else $error("superfine applied outside its modes");

  a_fine_range: assert property (@(posedge core_clk) disable iff (rst) // R10
    fine_delay_applied < fine_steps_long && superfine_delay_applied < superfine_steps)
    else $error("delay beyond step range");

  a_fine_immediate: assert property (@(posedge core_clk) disable iff (rst) // R13
    reg_wr_en && reg_addr == addr_fine && fine_enabled(old_mode) && !old_mode[mode_short_bit]
    |=> fine_delay_applied == clamp_steps($past(reg_wr_data), fine_steps_long))
    else $error("fine delay not applied at once");

  a_stab_reset_on: assert property (@(posedge core_clk) // R17
    rst |=> cur.stab_one[stab_enable_bit] && cur.stab_two[stab_enable_bit])
    else $error("stabilizer not enabled out of reset");

  a_catchup_quiet: assert property (@(posedge core_clk) disable iff (rst) // R19
    cur.realigned |=> !sample_strobe)
    else $error("catch-up edge after realignment gave a sample strobe");

  a_short_range: assert property (@(posedge core_clk) disable iff (rst) // R9
    old_mode[mode_short_bit] |-> fine_delay_applied < fine_steps_short)
    else $error("short fine delay beyond its step range");

  a_superfine_mode: assert property (@(posedge core_clk) disable iff (rst) // R12
    superfine_active |-> old_mode == mode_superfine_a || old_mode == mode_superfine_b)
    else $error("superfine active in a fine-only mode");

  a_mode_no_pulse: assert property (@(posedge core_clk) disable iff (rst) // R14
    wr_mode && old_mode != mode_off |=> !datapath_reset)
    else $error("mode write with fine delay already on reset the datapath");

  c_realign: cover property (@(posedge core_clk) disable iff (rst)
    div_edge && cur.sysref_pending && ratio == ratio_div4);
  c_datapath_reset: cover property (@(posedge core_clk) disable iff (rst) datapath_reset);
  c_half_shift: cover property (@(posedge core_clk) disable iff (rst)
    half_on && div_edge && ratio == ratio_div2);
  c_superfine_div2: cover property (@(posedge core_clk) disable iff (rst)
    superfine_active && ratio == ratio_div2 && sample_strobe);
endmodule
`default_nettype wire

// ==== test/clock_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module clock_source_model (
  input  wire logic       core_clk,
  input  wire logic       run,
  input  wire logic [7:0] half_cycles,
  input  wire logic       fire_sysref,
  output logic            clk_in_pin,
  output logic            sysref_pin
);
  logic [7:0] cnt;
  logic       armed;
  logic [2:0] hold;
  logic       go;

  initial
  begin
    clk_in_pin = 1'b0;
    sysref_pin = 1'b0;
    cnt = 8'h00;
    armed = 1'b0;
    hold = 3'h0;
    go = 1'b0;
  end

  // inputs sampled at the edge, pins moved just after it
  always @(posedge core_clk)
  begin
    armed = armed | fire_sysref;
    go = run;
    #1;
    if (hold != 3'h0)
    begin
      hold = hold - 3'h1;
      sysref_pin = (hold != 3'h0);
    end
    // input toggles no faster than every half_cycles core cycles
    if (go && cnt >= half_cycles - 8'h01)
    begin
      cnt = 8'h00;
      clk_in_pin = ~clk_in_pin;
      // pulse launched on an input rise so its phase repeats
      if (clk_in_pin && armed)
      begin
        armed = 1'b0;
        hold = 3'h4;
        sysref_pin = 1'b1;
      end
    end
    else if (go)
      cnt = cnt + 8'h01;
  end
endmodule
`default_nettype wire

// ==== test/sample_clock_divider_delay_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module sample_clock_divider_delay_tb;
  import sample_clock_pkg::*;
  typedef struct packed
  {
    logic [2:0] mode;
    logic [7:0] fine;
    logic [7:0] sfine;
    logic [7:0] exp_fine;
    logic [7:0] exp_sf;
    logic       exp_act;
    logic       exp_pulse;
  } row_type;

  logic        core_clk;
  logic        rst;
  logic        clk_in_pin;
  logic        sysref_pin;
  logic        reg_wr_en;
  logic        reg_rd_en;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wr_data;
  logic [7:0]  reg_rd_data;
  logic        reg_rd_valid;
  logic        div_clk;
  logic        sample_strobe;
  logic [7:0]  fine_delay_applied;
  logic [7:0]  superfine_delay_applied;
  logic        superfine_active;
  logic        datapath_reset;
  logic        run;
  logic        fire_sysref;
  int          n_mismatch;
  int          comparisons;
  int          cyc;
  int          dp_count;
  int          d0;
  int          p0;
  int          p1;
  int          rises;
  int          highs;
  int          dl [4];
  row_type     rows [10] = '{
    '{3'h0, 8'h30, 8'h30, 8'h00, 8'h00, 1'b0, 1'b0}, '{3'h1, 8'h50, 8'h40, 8'h50, 8'h00, 1'b0, 1'b1},
    '{3'h2, 8'hbf, 8'h7f, 8'hbf, 8'h7f, 1'b1, 1'b0}, '{3'h3, 8'hff, 8'h01, 8'hbf, 8'h00, 1'b0, 1'b0},
    '{3'h4, 8'h10, 8'h20, 8'h0f, 8'h00, 1'b0, 1'b0}, '{3'h5, 8'h0e, 8'h20, 8'h0e, 8'h00, 1'b0, 1'b0},
    '{3'h6, 8'h20, 8'h90, 8'h0f, 8'h7f, 1'b1, 1'b0}, '{3'h7, 8'h00, 8'h55, 8'h00, 8'h00, 1'b0, 1'b0},
    '{3'h0, 8'h12, 8'h12, 8'h00, 8'h00, 1'b0, 1'b0}, '{3'h6, 8'hc0, 8'h80, 8'h0f, 8'h7f, 1'b1, 1'b1}};
  int          edges [4] = '{2, 1, 4, 3};

  sample_clock_divider_delay u_dut (
    .core_clk(core_clk), .rst(rst), .clk_in_pin(clk_in_pin), .sysref_pin(sysref_pin),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .div_clk(div_clk),
    .sample_strobe(sample_strobe), .fine_delay_applied(fine_delay_applied),
    .superfine_delay_applied(superfine_delay_applied), .superfine_active(superfine_active),
    .datapath_reset(datapath_reset));

  clock_source_model u_source (
    .core_clk(core_clk), .run(run), .half_cycles(8'h04), .fire_sysref(fire_sysref),
    .clk_in_pin(clk_in_pin), .sysref_pin(sysref_pin));

  always #50 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (datapath_reset === 1'b1)
      dp_count <= dp_count + 1;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    #1;
    reg_wr_en = 1'b1;
    reg_addr = addr;
    reg_wr_data = data;
    cycles(1);
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
    @(posedge core_clk);
    #1;
    reg_rd_en = 1'b1;
    reg_addr = addr;
    cycles(1);
    reg_rd_en = 1'b0;
    chk1(reg_rd_valid, 1'b1);
    chk8(reg_rd_data, exp);
  endtask

  task automatic wait_strobe(output int at);
    int k;
    for (k = 0; k < 100 && sample_strobe !== 1'b1; k++)
      cycles(1);
    if (sample_strobe !== 1'b1)
    begin
      $display("ERROR %0t: no sample strobe", $time);
      n_mismatch++;
      wrap_up();
    end
    at = cyc;
  endtask

  task automatic measure();
    rises = 0;
    highs = 0;
    repeat (128)
    begin
      cycles(1);
      rises += (sample_strobe === 1'b1);
      highs += (div_clk === 1'b1);
    end
  endtask

  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    {reg_wr_en, reg_rd_en, run, fire_sysref} = 4'h0;
    reg_addr = 16'h0000;
    reg_wr_data = 8'h00;
    n_mismatch = 0;
    comparisons = 0;
    cyc = 0;
    dp_count = 0;
    repeat (16) @(posedge core_clk);
    #1;
    rst = 1'b0;
    cycles(1);
    chk1(div_clk | sample_strobe | superfine_active | datapath_reset, 1'b0);
    chk8(fine_delay_applied | superfine_delay_applied, 8'h00);
    rd(addr_divide_ratio, reset_divide_ratio);
    rd(addr_half_period, reset_half_period);
    rd(addr_delay_mode, reset_delay_mode);
    rd(addr_stabilizer_one, 8'h01);
    rd(addr_stabilizer_two, 8'h01);
    wr(16'h0200, 8'h5a);
    rd(16'h0200, 8'h00);
    wr(addr_status, 8'hff);
    rd(addr_status, 8'h00);
    $display("reset and register map test done");
    foreach (rows[i])
    begin
      d0 = dp_count;
      wr(addr_fine, rows[i].fine);
      wr(addr_superfine, rows[i].sfine);
      wr(addr_delay_mode, {5'h00, rows[i].mode});
      cycles(1);
      chk8(fine_delay_applied, rows[i].exp_fine);
      chk8(superfine_delay_applied, rows[i].exp_sf);
      chk1(superfine_active, rows[i].exp_act);
      rd(addr_fine, rows[i].fine);
      rd(addr_superfine, rows[i].sfine);
      chk8(8'(dp_count - d0), {7'h00, rows[i].exp_pulse});
    end
    $display("delay table test done");
    for (int code = 0; code < 4; code++)
    begin
      run = 1'b0;
      wr(addr_divide_ratio, 8'(code));
      run = 1'b1;
      cycles(80);
      measure();
      chk8(8'(rises), (code == 1) ? 8'h08 : (code == 2) ? 8'h04 : 8'h10);
      chk8(8'(highs), 8'h40);
    end
    $display("divide ratio test done");
    wr(addr_divide_ratio, {6'h00, ratio_div2});
    cycles(40);
    wait_strobe(p0);
    d0 = dp_count;
    wr(addr_half_period, 8'h01);
    cycles(40);
    wait_strobe(p1);
    chk8(8'((p1 - p0) % 8), 8'h04);
    chk8(8'(dp_count - d0), 8'h00);
    wr(addr_half_period, 8'h00);
    $display("half period test done");
    for (int ld = 0; ld < 4; ld++)
    begin
      wr(addr_divide_ratio, {2'h0, 2'(ld), 2'h0, ratio_div4});
      cycles(40);
      fire_sysref = 1'b1;
      cycles(1);
      fire_sysref = 1'b0;
      #1;
      for (int k = 0; k < 20 && sysref_pin !== 1'b1; k++)
      begin
        cycles(1);
        #1;
      end
      if (sysref_pin !== 1'b1)
      begin
        $display("ERROR %0t: no timing pulse", $time);
        n_mismatch++;
        wrap_up();
      end
      d0 = cyc;
      cycles(8);
      wait_strobe(p1);
      dl[ld] = p1 - d0;
      chk8(8'(dl[ld] - dl[0] + 16), 8'(8 * edges[ld]));
    end
    $display("timing pulse realign test done");
    wrap_up();
  end
endmodule
`default_nettype wire
